// File: src/adc_ctrl_pkg.sv
// Constants, states and carriers for the converter control block
package adc_ctrl_pkg;

   // ==========================================
   // Clock and timing
   localparam int CLK_NS     = 50;
   localparam int START_NS   = 40;
   localparam int START_RAW  = (START_NS + CLK_NS - 1) / CLK_NS;
   localparam int START_CYC  = (START_RAW < 1) ? 1 : START_RAW;
   localparam int CONV_NS    = 2200;
   localparam int CONV_RAW   = CONV_NS / CLK_NS;
   localparam int CONV_CYC   = (CONV_RAW < 1) ? 1 : CONV_RAW;

   // ==========================================
   // Widths and reset values
   localparam int RES_W      = 16;
   localparam int HALF_W     = 8;
   localparam int CNT_W      = 12;
   localparam int LOW_W      = 4;
   localparam logic [RES_W-1:0] RESULT_RST = 16'h0000;
   localparam logic [CNT_W-1:0] CNT_RST    = 12'h000;
   localparam logic [LOW_W-1:0] LOW_RST    = 4'h0;

   // ==========================================
   // Conversion states
   typedef enum logic [2:0] {
      ST_TRACK = 3'b001,
      ST_CONV  = 3'b010,
      ST_LOAD  = 3'b100
   } conv_state_e;

   // ==========================================
   // Carriers
   typedef struct packed {
      logic cs_n;
      logic rc;
      logic byte_sel;
   } ctrl_pins_s;

   typedef struct packed {
      conv_state_e      st;
      logic [LOW_W-1:0] low_cnt;
      logic             armed;
      logic [CNT_W-1:0] cnt;
      logic [RES_W-1:0] sample;
      logic [RES_W-1:0] result;
      logic [RES_W-1:0] bus_data;
   } conv_regs_s;

endpackage

// File: src/adc_ctrl.sv
// Control and parallel readout logic of a sampling SAR converter
`timescale 1ns/1ps

// Operation
// - Bus driven only when select low, read high
// - Both selects low 40 ns starts conversion
// - Busy low from start until result loaded
// - Two's-complement results, MSB on top line
// - Tracking resumes when conversion ends
// - Convert command during busy aborts conversion
// - Selects ORed, level triggered, any order
// - Select tied low: read high enables bus
// - Conversion start leaves bus high impedance
// - Select fall while idle shows latest result
// - During conversion previous result is shown
// - Result read as word or two halves
// - Half select swaps halves onto byte lanes
module adc_ctrl
   import adc_ctrl_pkg::*;
#(
   parameter int CONV_CYCLES = CONV_CYC,
   parameter int START_CYCLES = START_CYC
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             ce,
   input  wire logic             cs_n,
   input  wire logic             rc,
   input  wire logic             byte_sel,
   input  wire logic [RES_W-1:0] sample_in,
   output logic                  busy_n,
   output logic                  hold,
   output logic [RES_W-1:0]      result_bus_o,
   output logic                  result_bus_oe
);

   // ==========================================
   // Pin grouping
   ctrl_pins_s pins;
   conv_regs_s q;
   conv_regs_s d;

   logic req_low;
   logic fire;

   localparam logic [CNT_W-1:0] CONV_LAST  = CNT_W'(CONV_CYCLES - 1);
   localparam logic [LOW_W-1:0] START_LAST = LOW_W'(START_CYCLES - 1);

   assign pins.cs_n     = cs_n;
   assign pins.rc       = rc;
   assign pins.byte_sel = byte_sel;

   // ==========================================
   // Bus enable and status outputs
   // Enable is a pure function of the two selects; no state involved
   assign result_bus_oe = ~pins.cs_n & pins.rc;
   assign result_bus_o  = q.bus_data;
   assign busy_n        = (q.st == ST_TRACK);
   assign hold          = (q.st != ST_TRACK);

   // ==========================================
   // Convert command qualification
   // Combined low level of both selects is the command, so the
   // order in which they fall does not matter
   assign req_low = ~(pins.cs_n | pins.rc);

   // ==========================================
   // Next state
   always_comb begin
      d    = q;
      fire = 1'b0;

      // One command per low period; must release before the next
      if (!req_low) begin
         d.low_cnt = LOW_RST;
         d.armed   = 1'b0;
      end else if (!q.armed) begin
         if (q.low_cnt >= START_LAST) begin
            fire    = 1'b1;
            d.armed = 1'b1;
         end else begin
            d.low_cnt = q.low_cnt + LOW_W'(1);
         end
      end

      case (q.st)
         ST_TRACK: begin
            if (fire) begin
               d.st     = ST_CONV;
               d.cnt    = CNT_RST;
               d.sample = sample_in;
            end
         end
         ST_CONV: begin
            if (fire) begin
               // Abort throws the sample away; result stays as it was
               d.st  = ST_TRACK;
               d.cnt = CNT_RST;
            end else if (q.cnt >= CONV_LAST) begin
               d.st = ST_LOAD;
            end else begin
               d.cnt = q.cnt + CNT_W'(1);
            end
         end
         ST_LOAD: begin
            d.st  = ST_TRACK;
            d.cnt = CNT_RST;
            if (!fire) begin
               // Result and busy change on the same edge
               d.result = q.sample;
            end
         end
         default: begin
            d.st  = ST_TRACK;
            d.cnt = CNT_RST;
         end
      endcase

      // Output word follows the updated result, so the bus already
      // carries the new value at the busy rise; earlier result held
      // throughout a conversion
      if (pins.byte_sel) begin
         d.bus_data = {d.result[HALF_W-1:0], d.result[RES_W-1:HALF_W]};
      end else begin
         d.bus_data = d.result;
      end
   end

   // ==========================================
   // State register
   always_ff @(posedge clk) begin
      if (rst) begin
         q.st       <= ST_TRACK;
         q.low_cnt  <= LOW_RST;
         q.armed    <= 1'b1;
         q.cnt      <= CNT_RST;
         q.sample   <= RESULT_RST;
         q.result   <= RESULT_RST;
         q.bus_data <= RESULT_RST;
      end else if (ce) begin
         q <= d;
      end
   end

endmodule // adc_ctrl

// File: src/unused_placeholder_removed.sv
// Intentionally empty design note file
`timescale 1ns/1ps

// File: tb/adc_ctrl_properties.sv
// Checker for the converter control block
`timescale 1ns/1ps
module adc_ctrl_checker
   import adc_ctrl_pkg::*;
(
   input wire logic             clk,
   input wire logic             rst,
   input wire logic             cs_n,
   input wire logic             rc,
   input wire logic             byte_sel,
   input wire logic             busy_n,
   input wire logic             hold,
   input wire logic [RES_W-1:0] result_bus_o,
   input wire logic             result_bus_oe
);
   // ======
   // Checks
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // Fresh command only, a held low pair fires once
   sequence fire_s; !cs_n && !rc && $past(cs_n || rc); endsequence
   chk_bus_enable: assert property (result_bus_oe == (!cs_n && rc))
      else $error("bus enable wrong");
   chk_hold_track: assert property (hold == !busy_n)
      else $error("hold not inverse of busy");
   chk_busy_cause: assert property ($fell(busy_n) |-> $past(!cs_n && !rc))
      else $error("busy fell without command");
   chk_busy_bound: assert property ($fell(busy_n) |-> ##[1:5] busy_n)
      else $error("busy too long");
   chk_start_fire: assert property (fire_s ##0 busy_n |=> !busy_n)
      else $error("conversion did not start");
   chk_abort_run: assert property (fire_s ##0 !busy_n |=> busy_n)
      else $error("abort ignored");
   chk_prev_held: assert property (!busy_n && $past(!busy_n) &&
      $past(byte_sel) == $past(byte_sel, 2) |-> $stable(result_bus_o))
      else $error("previous result disturbed");
   chk_byte_swap: assert property ($changed(byte_sel) && busy_n |=>
      result_bus_o == {$past(result_bus_o[7:0]), $past(result_bus_o[15:8])})
      else $error("halves not swapped");
endmodule // adc_ctrl_checker

bind adc_ctrl adc_ctrl_checker adc_ctrl_checker_i (.clk, .rst, .cs_n, .rc, .byte_sel,
   .busy_n, .hold, .result_bus_o, .result_bus_oe);

// File: tb/host_model.sv
// Host side model latching converter results
`timescale 1ns/1ps
module host_model
   import adc_ctrl_pkg::*;
(
   input  wire logic             clk,
   input  wire logic             busy_n,
   input  wire logic             result_bus_oe,
   input  wire logic [RES_W-1:0] result_bus_o,
   output logic      [RES_W-1:0] latched_q
);
   logic busy_q;
   // ======
   // Latch
   // One edge after the busy rise, so the bus has settled
   always_ff @(posedge clk) begin
      busy_q <= busy_n;
      if (busy_n && !busy_q && result_bus_oe) latched_q <= result_bus_o;
   end
endmodule // host_model

// File: tb/tb_sar_adc_parallel_host_interface.sv
// Testbench for the converter control block
`timescale 1ns/1ps
module tb_sar_adc_parallel_host_interface
   import adc_ctrl_pkg::*;
;
   typedef struct packed {logic [15:0] smp; logic bsel; logic [15:0] exp;} row_s;
   logic             clk = 1'b0;
   logic             rst = 1'b1;
   logic             busy_n, hold, oe;
   ctrl_pins_s       pins = 3'b110;
   logic [RES_W-1:0] smp = 16'h0000;
   logic [RES_W-1:0] bus, got;
   int               failures = 0, check_count = 0, cyc = 0;
   row_s rows [5] = '{'{16'h7FFF, 1'b0, 16'h7FFF}, '{16'h0000, 1'b0, 16'h0000},
      '{16'hFFFF, 1'b0, 16'hFFFF}, '{16'h8000, 1'b0, 16'h8000}, '{16'h8000, 1'b1, 16'h0080}};
   always #25 clk = ~clk;
   // Short conversion keeps the run brief
   adc_ctrl #(.CONV_CYCLES(4)) adc_ctrl_i (.clk, .rst, .ce(1'b1), .cs_n(pins.cs_n),
      .rc(pins.rc), .byte_sel(pins.byte_sel), .sample_in(smp), .busy_n, .hold,
      .result_bus_o(bus), .result_bus_oe(oe));
   host_model host_model_i (.clk, .busy_n, .result_bus_oe(oe), .result_bus_o(bus),
      .latched_q(got));
   // =====
   // Tasks
   task automatic chk(input logic [15:0] g, input logic [15:0] e);
      check_count++;
      if (g !== e) begin
         failures++;
         $display("mismatch t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic conv(input logic [15:0] s);
      int i;
      @(negedge clk) {pins.cs_n, pins.rc, smp} = {2'b00, s};
      @(negedge clk) pins.rc = 1'b1;
      for (i = 0; i < 9 && busy_n !== 1'b1; i++) @(negedge clk);
      @(negedge clk);
   endtask
   task automatic conclude;
      if (failures == 0 && check_count > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc++;
      if (cyc == 400) begin
         failures++;
         conclude;
      end
   end
   // =====
   // Tests
   initial begin
      repeat (6) @(negedge clk);
      rst = 1'b0;
      chk(bus, RESULT_RST);
      chk({14'h0000, hold, busy_n}, 16'h0001);
      foreach (rows[k]) begin
         pins.byte_sel = rows[k].bsel;
         conv(rows[k].smp);
         chk(got, rows[k].exp);
      end
      @(negedge clk) pins.byte_sel = 1'b0;
      @(negedge clk) chk(bus, 16'h8000);
      @(negedge clk) {pins.rc, smp} = {1'b0, 16'h1234};
      @(negedge clk) pins.rc = 1'b1;
      @(negedge clk) chk(bus, 16'h8000);
      @(negedge clk) pins.rc = 1'b0;
      @(negedge clk) pins.rc = 1'b1;
      @(negedge clk) chk({15'h0000, busy_n}, 16'h0001);
      chk(bus, 16'h8000);
      // Aborted sample must never reach the result
      repeat (6) @(negedge clk);
      chk(bus, 16'h8000);
      chk({15'h0000, oe}, 16'h0001);
      pins.cs_n = 1'b1;
      @(negedge clk) chk({15'h0000, oe}, 16'h0000);
      pins.rc = 1'b0;
      @(negedge clk) pins.cs_n = 1'b0;
      @(negedge clk) chk({13'h0000, hold, oe, busy_n}, 16'h0004);
      pins.cs_n = 1'b1;
      pins.rc = 1'b1;
      repeat (6) @(negedge clk);
      pins.cs_n = 1'b0;
      @(negedge clk) chk(bus, 16'h1234);
      chk({15'h0000, oe}, 16'h0001);
      conclude;
   end
endmodule // tb_sar_adc_parallel_host_interface
